// ---- src/sector_fmt_pkg.sv ----
// Constants and types shared by the drive end and the controller end.
// Operation
// - Code 01011 is index, once per track
// - Code 01110 is inner guard band two
// - Code 01010 is inner guard band one
// - Code 10011 is outer guard band
// - Normal bit is 0, missing bit 1
// - Cylinder low two bits pick servo pair
// - Cylinders 0 to 822 only
// - Leading gap at least 18 bytes
// - Sync byte is hex 19
// - Address and data sync may differ
// - Gaps, preambles, splice, pad are zero
// - Sectors per track 1 to 128 by switches
// - Trailing gap 15 bytes for 256 data
// - Address: flag, cyl hi, lo, head, sector
// - Address check bytes written, verified on read
// - Split write turns on inside splice
// - Drive gives index and sector pulses
// - Flag byte meaning owned by controller
// - Data gets check bytes, then pad
package sector_fmt_pkg;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [4:0] INDEX_CODE = 5'h0b;
   localparam logic [4:0] IGB_TWO_CODE = 5'h0e;
   localparam logic [4:0] IGB_ONE_CODE = 5'h0a;
   localparam logic [4:0] OGB_CODE = 5'h13;
   localparam logic [15:0] TRACK_BYTES = 16'ha000;
   localparam int SYNC_PER_TRACK = 5120;
   localparam int GUARD_SYNC_INTERVAL = 64;
   localparam logic [9:0] CYL_MAX = 10'h0336;
   localparam logic [7:0] SECT_MIN = 8'h01;
   localparam logic [7:0] SECT_MAX = 8'h80;
   localparam logic [4:0] DIV_STEPS = 5'h10;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] ADDR_SYNC_BYTE = 8'h19;
   localparam logic [7:0] DATA_SYNC_BYTE = 8'h19;
   localparam logic [7:0] FILL_BYTE = 8'h00;
   localparam logic [8:0] GAP1_LEN = 9'h012;
   localparam logic [8:0] PRE_LEN = 9'h008;
   localparam logic [8:0] SYNC_LEN = 9'h001;
   localparam logic [8:0] ADDR_LEN = 9'h005;
   localparam logic [8:0] CHK_LEN = 9'h002;
   localparam logic [8:0] SPLICE_LEN = 9'h003;
   localparam logic [8:0] DATA_LEN = 9'h100;
   localparam logic [8:0] EOR_LEN = 9'h001;
   localparam logic [8:0] GAP3_LEN = 9'h00f;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      PAIR_ODD_PHASE_ONE_PATTERN_EVEN_PHASE_TWO_PATTERN = 2'b00,
      PAIR_ODD_PHASE_ONE_PATTERN_ODD_PHASE_TWO_PATTERN = 2'b01,
      PAIR_EVEN_PHASE_ONE_PATTERN_ODD_PHASE_TWO_PATTERN = 2'b10,
      PAIR_EVEN_PHASE_ONE_PATTERN_EVEN_PHASE_TWO_PATTERN = 2'b11
   } servo_pair_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_GAP1 = 4'b0001,
      ST_PRE1 = 4'b0010,
      ST_SYNC1 = 4'b0011,
      ST_ADDR = 4'b0100,
      ST_CRC = 4'b0101,
      ST_SPLICE = 4'b0110,
      ST_PRE2 = 4'b0111,
      ST_SYNC2 = 4'b1000,
      ST_DATA = 4'b1001,
      ST_ECC = 4'b1010,
      ST_EOR = 4'b1011,
      ST_GAP3 = 4'b1100,
      ST_RD_HUNT = 4'b1101,
      ST_RD_ADDR = 4'b1110
   } fmt_state_t;

   function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                            input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {data, 8'h00};
      for (int i = 0; i < 8; i++) begin
         c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction
endpackage

// ---- src/sector_link_if.sv ----
// Byte-timed link between the drive end and the controller end.
interface sector_link_if;
   logic byte_tick;
   logic index_pulse;
   logic sector_pulse;
   logic [7:0] sector_num;
   logic [7:0] read_byte;
   logic read_valid;
   logic write_gate;
   logic [7:0] write_byte;
   logic [9:0] target_cyl;

   modport drive (
      output byte_tick, index_pulse, sector_pulse, sector_num,
      output read_byte, read_valid,
      input write_gate, write_byte, target_cyl
   );
   modport ctrl (
      input byte_tick, index_pulse, sector_pulse, sector_num,
      input read_byte, read_valid,
      output write_gate, write_byte, target_cyl
   );
endinterface

// ---- src/servo_drive_end.sv ----
// Drive end: servo sync decode, index and sector pulse generation.
module servo_drive_end
   import sector_fmt_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   sector_link_if.drive link,
   input wire logic servo_bit_valid_i,
   input wire logic servo_bit_missing_i,
   input wire logic byte_tick_i,
   input wire logic [7:0] sector_switch_i,
   input wire logic [7:0] head_byte_i,
   input wire logic head_valid_i,
   output logic index_det_o,
   output logic inner_guard_band_two_o,
   output logic inner_guard_band_one_o,
   output logic outer_guard_band_o,
   output servo_pair_t servo_pair_o,
   output logic cyl_invalid_o,
   output logic write_gate_o,
   output logic [7:0] write_byte_o
);
   ////////////////////////////////////////////////////////////////////////
   logic [4:0] shift_reg;
   logic index_start_reg;
   logic [15:0] byte_cnt_reg;
   logic [7:0] sect_num_reg;
   logic sect_pulse_reg;
   logic idx_pulse_reg;
   logic [7:0] div_n_reg;
   logic [15:0] div_rem_reg;
   logic [15:0] div_quo_reg;
   logic [4:0] div_cnt_reg;
   logic [15:0] sector_len_reg;
   logic [7:0] rd_byte_reg;
   logic rd_valid_reg;

   wire logic [4:0] shift_next = {shift_reg[3:0], servo_bit_missing_i};
   wire logic index_hit = servo_bit_valid_i && shift_next == INDEX_CODE;
   wire logic [7:0] sect_count = (sector_switch_i < SECT_MIN) ? SECT_MIN :
      (sector_switch_i > SECT_MAX) ? SECT_MAX : sector_switch_i;
   wire logic div_start = div_cnt_reg == 5'h00 && sect_count != div_n_reg;
   wire logic [16:0] div_shift = {div_rem_reg, div_quo_reg[15]};
   wire logic div_fit = div_shift >= {9'h000, div_n_reg};
   wire logic [16:0] div_sub = div_shift - {9'h000, div_n_reg};
   wire logic sect_end = byte_cnt_reg == sector_len_reg - 16'h0001 &&
      sect_num_reg < div_n_reg - 8'h01;

   ////////////////////////////////////////////////////////////////////////
   // Each detector stays up until the next sync bit arrives
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shift_reg <= 5'h00;
         index_det_o <= 1'b0;
         inner_guard_band_two_o <= 1'b0;
         inner_guard_band_one_o <= 1'b0;
         outer_guard_band_o <= 1'b0;
      end else if (servo_bit_valid_i) begin
         shift_reg <= shift_next;
         index_det_o <= shift_next == INDEX_CODE;
         inner_guard_band_two_o <= shift_next == IGB_TWO_CODE;
         inner_guard_band_one_o <= shift_next == IGB_ONE_CODE;
         outer_guard_band_o <= shift_next == OGB_CODE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequential divide keeps the 200 MHz path short; switch changes take
   // effect after seventeen clocks: one load, then sixteen divide steps
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_n_reg <= 8'h00;
         div_rem_reg <= 16'h0000;
         div_quo_reg <= 16'h0000;
         div_cnt_reg <= 5'h00;
         sector_len_reg <= TRACK_BYTES;
      end else if (div_start) begin
         div_n_reg <= sect_count;
         div_rem_reg <= 16'h0000;
         div_quo_reg <= TRACK_BYTES;
         div_cnt_reg <= DIV_STEPS;
      end else if (div_cnt_reg != 5'h00) begin
         div_rem_reg <= div_fit ? div_sub[15:0] : div_shift[15:0];
         div_quo_reg <= {div_quo_reg[14:0], div_fit};
         div_cnt_reg <= div_cnt_reg - 5'h01;
         if (div_cnt_reg == 5'h01) begin
            sector_len_reg <= {div_quo_reg[14:0], div_fit};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Leftover bytes of an uneven split fall into the last sector
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         index_start_reg <= 1'b0;
         byte_cnt_reg <= 16'h0000;
         sect_num_reg <= 8'h00;
         sect_pulse_reg <= 1'b0;
         idx_pulse_reg <= 1'b0;
      end else begin
         sect_pulse_reg <= 1'b0;
         idx_pulse_reg <= 1'b0;
         if (byte_tick_i) begin
            index_start_reg <= 1'b0;
         end else if (index_hit) begin
            index_start_reg <= 1'b1;
         end
         if (byte_tick_i) begin
            if (index_start_reg || index_hit) begin
               byte_cnt_reg <= 16'h0000;
               sect_num_reg <= 8'h00;
               idx_pulse_reg <= 1'b1;
               sect_pulse_reg <= 1'b1;
            end else if (sect_end) begin
               byte_cnt_reg <= 16'h0000;
               sect_num_reg <= sect_num_reg + 8'h01;
               sect_pulse_reg <= 1'b1;
            end else if (byte_cnt_reg != TRACK_BYTES - 16'h0001) begin
               byte_cnt_reg <= byte_cnt_reg + 16'h0001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_byte_reg <= 8'h00;
         rd_valid_reg <= 1'b0;
         write_gate_o <= 1'b0;
         write_byte_o <= 8'h00;
         servo_pair_o <= PAIR_ODD_PHASE_ONE_PATTERN_EVEN_PHASE_TWO_PATTERN;
         cyl_invalid_o <= 1'b0;
      end else begin
         rd_byte_reg <= head_byte_i;
         rd_valid_reg <= head_valid_i && byte_tick_i;
         write_gate_o <= link.write_gate;
         write_byte_o <= link.write_byte;
         servo_pair_o <= servo_pair_t'(link.target_cyl[1:0]);
         cyl_invalid_o <= link.target_cyl > CYL_MAX;
      end
   end

   assign link.byte_tick = byte_tick_i;
   assign link.index_pulse = idx_pulse_reg;
   assign link.sector_pulse = sect_pulse_reg;
   assign link.sector_num = sect_num_reg;
   assign link.read_byte = rd_byte_reg;
   assign link.read_valid = rd_valid_reg;
endmodule

// ---- src/disk_ctrl_end.sv ----
// Controller end: fixed sector writer and address area checker.
module disk_ctrl_end
   import sector_fmt_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   sector_link_if.ctrl link,
   input wire logic write_req_i,
   input wire logic read_req_i,
   input wire logic data_only_i,
   input wire logic [7:0] flag_i,
   input wire logic [9:0] cyl_i,
   input wire logic [7:0] head_i,
   input wire logic [7:0] sector_i,
   input wire logic [7:0] data_byte_i,
   output logic data_take_o,
   output logic busy_o,
   output logic done_o,
   output logic hdr_ok_o,
   output logic hdr_bad_o,
   output logic cyl_reject_o
);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [8:0] field_len(input fmt_state_t s);
      case (s)
         ST_GAP1: field_len = GAP1_LEN;
         ST_PRE1: field_len = PRE_LEN;
         ST_PRE2: field_len = PRE_LEN;
         ST_SYNC1: field_len = SYNC_LEN;
         ST_SYNC2: field_len = SYNC_LEN;
         ST_ADDR: field_len = ADDR_LEN;
         ST_RD_ADDR: field_len = ADDR_LEN + CHK_LEN;
         ST_CRC: field_len = CHK_LEN;
         ST_ECC: field_len = CHK_LEN;
         ST_SPLICE: field_len = SPLICE_LEN;
         ST_DATA: field_len = DATA_LEN;
         ST_EOR: field_len = EOR_LEN;
         ST_GAP3: field_len = GAP3_LEN;
         default: field_len = SYNC_LEN;
      endcase
   endfunction

   function automatic fmt_state_t next_field(input fmt_state_t s);
      case (s)
         ST_GAP1: next_field = ST_PRE1;
         ST_PRE1: next_field = ST_SYNC1;
         ST_SYNC1: next_field = ST_ADDR;
         ST_ADDR: next_field = ST_CRC;
         ST_CRC: next_field = ST_SPLICE;
         ST_SPLICE: next_field = ST_PRE2;
         ST_PRE2: next_field = ST_SYNC2;
         ST_SYNC2: next_field = ST_DATA;
         ST_DATA: next_field = ST_ECC;
         ST_ECC: next_field = ST_EOR;
         ST_EOR: next_field = ST_GAP3;
         default: next_field = ST_IDLE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   fmt_state_t state_reg;
   fmt_state_t state_next;
   logic [8:0] fcnt_reg;
   logic [15:0] crc_reg;
   logic is_write_reg;
   logic split_reg;
   logic [7:0] flag_reg;
   logic [9:0] cyl_reg;
   logic [7:0] head_reg;
   logic [7:0] sect_reg;
   logic [39:0] rd_addr_reg;
   logic gate_reg;
   logic [7:0] wbyte_reg;

   wire logic tick = link.byte_tick;
   wire logic field_last = fcnt_reg == field_len(state_reg) - 9'h001;
   wire logic cyl_ok = cyl_i <= CYL_MAX;
   wire logic start_ok = state_reg == ST_IDLE && !busy_o && cyl_ok &&
      (write_req_i || read_req_i);
   wire logic sector_hit = link.sector_pulse && link.sector_num == sect_reg;
   wire logic [7:0] addr_byte =
      fcnt_reg == 9'h000 ? flag_reg :
      fcnt_reg == 9'h001 ? {6'h00, cyl_reg[9:8]} :
      fcnt_reg == 9'h002 ? cyl_reg[7:0] :
      fcnt_reg == 9'h003 ? head_reg : sect_reg;
   wire logic [7:0] chk_byte = fcnt_reg == 9'h000 ? crc_reg[15:8] :
      crc_reg[7:0];
   wire logic [7:0] out_byte =
      state_reg == ST_SYNC1 ? ADDR_SYNC_BYTE :
      state_reg == ST_SYNC2 ? DATA_SYNC_BYTE :
      state_reg == ST_ADDR ? addr_byte :
      state_reg == ST_DATA ? data_byte_i :
      state_reg == ST_CRC || state_reg == ST_ECC ? chk_byte :
      FILL_BYTE;
   wire logic crc_run = state_reg == ST_ADDR || state_reg == ST_DATA;
   wire logic crc_seed = state_reg == ST_SYNC1 || state_reg == ST_SYNC2;
   // A split write leaves the head off until the splice field
   wire logic gate_on = is_write_reg && state_reg != ST_IDLE &&
      (!split_reg || state_reg >= ST_SPLICE);
   wire logic rd_byte_ok = link.read_valid;
   wire logic [15:0] rd_crc_next = crc_step(crc_reg, link.read_byte);
   wire logic [39:0] want_addr =
      {flag_reg, 6'h00, cyl_reg, head_reg, sect_reg};

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            state_next = ST_IDLE;
         end
         ST_RD_HUNT: begin
            if (rd_byte_ok && link.read_byte == ADDR_SYNC_BYTE) begin
               state_next = ST_RD_ADDR;
            end else if (link.sector_pulse) begin
               state_next = ST_IDLE;
            end
         end
         ST_RD_ADDR: begin
            if (rd_byte_ok && field_last) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            if (tick && field_last) begin
               state_next = next_field(state_reg);
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_IDLE;
         fcnt_reg <= 9'h000;
         is_write_reg <= 1'b0;
         split_reg <= 1'b0;
         flag_reg <= 8'h00;
         cyl_reg <= 10'h000;
         head_reg <= 8'h00;
         sect_reg <= 8'h00;
         busy_o <= 1'b0;
      end else begin
         if (start_ok) begin
            is_write_reg <= write_req_i;
            split_reg <= data_only_i;
            flag_reg <= flag_i;
            cyl_reg <= cyl_i;
            head_reg <= head_i;
            sect_reg <= sector_i;
            busy_o <= 1'b1;
         end else if (busy_o && state_reg == ST_IDLE && sector_hit) begin
            state_reg <= is_write_reg ? ST_GAP1 : ST_RD_HUNT;
            fcnt_reg <= 9'h000;
         end else begin
            if (state_next != state_reg) begin
               fcnt_reg <= 9'h000;
            end else if (state_reg == ST_RD_ADDR ? rd_byte_ok :
                         tick && state_reg != ST_RD_HUNT) begin
               fcnt_reg <= fcnt_reg + 9'h001;
            end
            state_reg <= state_next;
            if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
               busy_o <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Check is seeded at each sync so address and data runs stay separate
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         crc_reg <= CRC_INIT;
         rd_addr_reg <= 40'h00_0000_0000;
      end else if (state_reg == ST_RD_HUNT) begin
         crc_reg <= CRC_INIT;
      end else if (state_reg == ST_RD_ADDR && rd_byte_ok) begin
         crc_reg <= rd_crc_next;
         if (fcnt_reg < ADDR_LEN) begin
            rd_addr_reg <= {rd_addr_reg[31:0], link.read_byte};
         end
      end else if (tick && crc_seed) begin
         crc_reg <= CRC_INIT;
      end else if (tick && crc_run) begin
         crc_reg <= crc_step(crc_reg, out_byte);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gate_reg <= 1'b0;
         wbyte_reg <= 8'h00;
         done_o <= 1'b0;
         hdr_ok_o <= 1'b0;
         hdr_bad_o <= 1'b0;
         cyl_reject_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         hdr_ok_o <= 1'b0;
         hdr_bad_o <= 1'b0;
         cyl_reject_o <= state_reg == ST_IDLE && !busy_o &&
            (write_req_i || read_req_i) && !cyl_ok;
         if (tick) begin
            gate_reg <= gate_on;
            wbyte_reg <= gate_on ? out_byte : FILL_BYTE;
         end
         if (is_write_reg && tick && state_reg == ST_GAP3 && field_last) begin
            done_o <= 1'b1;
         end
         if (state_reg == ST_RD_ADDR && rd_byte_ok && field_last) begin
            // Residue of zero means the header and its check agree
            if (rd_crc_next == 16'h0000 && rd_addr_reg == want_addr) begin
               hdr_ok_o <= 1'b1;
            end else begin
               hdr_bad_o <= 1'b1;
            end
         end
         if (state_reg == ST_RD_HUNT && link.sector_pulse &&
             !(rd_byte_ok && link.read_byte == ADDR_SYNC_BYTE)) begin
            hdr_bad_o <= 1'b1;
         end
      end
   end

   assign data_take_o = tick && state_reg == ST_DATA;
   assign link.write_gate = gate_reg;
   assign link.write_byte = wbyte_reg;
   assign link.target_cyl = cyl_reg;
endmodule

// ---- bench/sector_link_checker.sv ----
// Concurrent checks on the link between drive end and controller end.
module sector_link_checker (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic byte_tick,
   input wire logic index_pulse,
   input wire logic sector_pulse,
   input wire logic [7:0] sector_num,
   input wire logic write_gate,
   input wire logic [7:0] write_byte,
   input wire logic [9:0] target_cyl
);
   ////////////////////////////////////////////////////////////////////////
   default clocking link_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   // Last sector announced, so each new one other than sector zero must be its successor
   logic [7:0] last_num_reg;
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         last_num_reg <= 8'h00;
      end else if (sector_pulse) begin
         last_num_reg <= sector_num;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   index_one_clk_a: assert property (
      index_pulse |=> !index_pulse) else $error("Index pulse too long");
   index_starts_a: assert property (
      index_pulse |-> sector_pulse && sector_num == 8'h00)
      else $error("Index without sector zero");
   pulse_on_tick_a: assert property (
      sector_pulse |-> $past(byte_tick)) else $error("Sector pulse off tick");
   sector_range_a: assert property (
      sector_pulse |-> sector_num < 8'h80) else $error("Sector out of range");
   sector_step_a: assert property (
      sector_pulse && sector_num != 8'h00 |->
      sector_num == last_num_reg + 8'h01)
      else $error("Sector number skipped");
   num_with_pulse_a: assert property (
      $changed(sector_num) |-> sector_pulse)
      else $error("Sector number moved without pulse");
   byte_on_tick_a: assert property (
      $changed(write_byte) |-> $past(byte_tick))
      else $error("Write byte changed off tick");
   idle_zero_a: assert property (
      !write_gate |-> write_byte == 8'h00) else $error("Byte while gate low");
   cyl_legal_a: assert property (
      write_gate |-> target_cyl <= 10'h336) else $error("Gate on bad cylinder");
   ////////////////////////////////////////////////////////////////////////
   index_seen_c: cover property (index_pulse);
   write_start_c: cover property ($rose(write_gate));
   sector_one_c: cover property (sector_pulse && sector_num == 8'h01);
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the drive end facing the controller end.
module testbench
   import sector_fmt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic servo_bit_valid_i = 1'b0;
   logic servo_bit_missing_i = 1'b0;
   logic byte_tick_i = 1'b0;
   logic head_valid_i = 1'b0;
   logic [7:0] head_byte_i = 8'h00;
   logic [7:0] data_byte_i = 8'h00;
   logic write_req_i = 1'b0;
   logic read_req_i = 1'b0;
   logic [9:0] cyl_i = 10'h000;
   logic [7:0] flag_i = 8'h00;
   logic [7:0] head_i = 8'h00;
   logic [7:0] sector_i = 8'h00;
   logic index_det_o, inner_guard_band_two_o, inner_guard_band_one_o;
   logic outer_guard_band_o, cyl_invalid_o, write_gate_o;
   logic [7:0] write_byte_o;
   logic data_only_i = 1'b0;
   servo_pair_t servo_pair_o;
   logic data_take_o, busy_o, done_o, hdr_ok_o, hdr_bad_o, cyl_reject_o;
   int bad_count = 0;
   int comparisons = 0;
   logic [1:0] tcnt = 2'b00;
   logic t1 = 1'b0;
   logic t2 = 1'b0;
   logic [7:0] dcount = 8'h00;
   logic [15:0] ticks = 16'h0000;
   logic [15:0] done_cnt = 16'h0000;
   logic [7:0] wq[$];
   logic [7:0] eq[$];
   logic [7:0] hq[$];

   sector_link_if link();
   servo_drive_end u_servo_drive_end (.sys_clk_i, .reset_n_i, .link,
      .servo_bit_valid_i, .servo_bit_missing_i, .byte_tick_i,
      .sector_switch_i(8'h80), .head_byte_i, .head_valid_i, .index_det_o,
      .inner_guard_band_two_o, .inner_guard_band_one_o, .outer_guard_band_o,
      .servo_pair_o, .cyl_invalid_o, .write_gate_o, .write_byte_o);
   disk_ctrl_end u_disk_ctrl_end (.sys_clk_i, .reset_n_i, .link,
      .write_req_i, .read_req_i, .data_only_i, .flag_i, .cyl_i,
      .head_i, .sector_i, .data_byte_i, .data_take_o, .busy_o, .done_o,
      .hdr_ok_o, .hdr_bad_o, .cyl_reject_o);
   sector_link_checker u_sector_link_checker (.sys_clk_i, .reset_n_i,
      .byte_tick(link.byte_tick), .index_pulse(link.index_pulse),
      .sector_pulse(link.sector_pulse), .sector_num(link.sector_num),
      .write_gate(link.write_gate), .write_byte(link.write_byte),
      .target_cyl(link.target_cyl));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   // One byte period is four clocks; head bytes ride on the tick
   always @(negedge sys_clk_i) begin
      tcnt = tcnt + 2'b01;
      byte_tick_i = (tcnt == 2'b00);
      head_valid_i = byte_tick_i && (hq.size() > 0);
      if (head_valid_i) begin
         head_byte_i = hq.pop_front();
      end
      data_byte_i = dcount ^ 8'h5a;
   end
   // Sample write bytes two clocks after the tick so both register stages are covered
   always @(posedge sys_clk_i) begin
      t1 <= link.byte_tick;
      t2 <= t1;
      ticks <= ticks + {15'h0000, link.byte_tick};
      done_cnt <= done_cnt + {15'h0000, done_o};
      if (data_take_o === 1'b1) begin
         dcount <= dcount + 8'h01;
      end
   end
   always @(negedge sys_clk_i) begin
      if (t2 && write_gate_o === 1'b1) begin
         wq.push_back(write_byte_o);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cmp(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_up(input string what);
      bad_count++;
      $display("Error %s expected event seen none", what);
      print_verdict();
   endtask

   function automatic logic [15:0] crc16(input logic [15:0] c,
                                         input logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      end
      return c;
   endfunction

   task automatic put(ref logic [7:0] q[$], input logic [7:0] b, input int n);
      repeat (n) q.push_back(b);
   endtask

   task automatic header(ref logic [7:0] q[$], input logic [7:0] s,
                         input logic bad);
      logic [7:0] h[5];
      logic [15:0] c;
      h = '{flag_i, {6'h00, cyl_i[9:8]}, cyl_i[7:0], head_i, s};
      c = CRC_INIT;
      q.push_back(8'h19);
      foreach (h[i]) begin
         c = crc16(c, h[i]);
         q.push_back(h[i]);
      end
      q.push_back(c[15:8]);
      q.push_back(c[7:0] ^ {7'h00, bad});
   endtask

   task automatic send_code(input logic [4:0] code, input logic [3:0] exp);
      for (int i = 4; i >= 0; i--) begin
         @(negedge sys_clk_i);
         servo_bit_valid_i = 1'b1;
         servo_bit_missing_i = code[i];
         @(negedge sys_clk_i);
         servo_bit_valid_i = 1'b0;
      end
      cmp("marker", {12'h000, exp}, {12'h000, index_det_o,
          inner_guard_band_two_o, inner_guard_band_one_o,
          outer_guard_band_o});
   endtask

   task automatic wait_busy;
      int n;
      for (n = 0; n < 8 && busy_o !== 1'b1; n++) @(negedge sys_clk_i);
      if (n == 8) give_up("busy");
   endtask

   task automatic wait_sector(input logic [7:0] s);
      int n;
      for (n = 0; n < 3000; n++) begin
         @(negedge sys_clk_i);
         if (link.sector_pulse === 1'b1 && link.sector_num === s) break;
      end
      if (n == 3000) give_up("sector pulse");
   endtask

   task automatic read_sector(input logic [7:0] s, input logic bad);
      int n;
      sector_i = s;
      read_req_i = 1'b1;
      wait_busy();
      read_req_i = 1'b0;
      wait_sector(s);
      put(hq, 8'h00, 3);
      header(hq, s, bad);
      for (n = 0; n < 400 && !(hdr_ok_o | hdr_bad_o); n++) begin
         @(negedge sys_clk_i);
      end
      if (n == 400) give_up("header verdict");
      cmp("header", {14'h0000, !bad, bad},
          {14'h0000, hdr_ok_o, hdr_bad_o});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [4:0] codes[4];
      logic [15:0] c;
      logic [15:0] t0;
      codes = '{IGB_TWO_CODE, IGB_ONE_CODE, OGB_CODE, INDEX_CODE};
      repeat (5) @(negedge sys_clk_i);
      reset_n_i = 1'b1;
      flag_i = 8'h40;
      head_i = 8'h03;
      cyl_i = 10'h337;
      write_req_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      cmp("cyl_reject", 16'h0001, {15'h0000, cyl_reject_o});
      cmp("busy", 16'h0000, {15'h0000, busy_o});
      cyl_i = 10'h336;
      sector_i = 8'h01;
      wait_busy();
      write_req_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      cmp("servo_pair", 16'h0002, 16'(servo_pair_o));
      cmp("cyl_invalid", 16'h0000, {15'h0000, cyl_invalid_o});
      for (int k = 0; k < 4; k++) begin
         send_code(codes[k], k == 3 ? 4'h8 : 4'h4 >> k);
      end
      wait_sector(8'h01);
      t0 = ticks;
      wait_sector(8'h02);
      cmp("sector_len", 16'd320, ticks - t0);
      repeat (8) @(negedge sys_clk_i);
      put(eq, 8'h00, 26);
      header(eq, 8'h01, 1'b0);
      put(eq, 8'h00, 11);
      eq.push_back(8'h19);
      c = CRC_INIT;
      for (int k = 0; k < 256; k++) begin
         eq.push_back(8'(k) ^ 8'h5a);
         c = crc16(c, 8'(k) ^ 8'h5a);
      end
      eq.push_back(c[15:8]);
      eq.push_back(c[7:0]);
      put(eq, 8'h00, 16);
      cmp("write_len", 16'd320, 16'(wq.size()));
      cmp("done", 16'h0001, done_cnt);
      foreach (eq[i]) begin
         cmp("write_byte", {8'h00, eq[i]}, {8'h00, wq[i]});
      end
      read_sector(8'h03, 1'b0);
      read_sector(8'h04, 1'b1);
      wq.delete();
      data_only_i = 1'b1;
      sector_i = 8'h05;
      write_req_i = 1'b1;
      wait_busy();
      write_req_i = 1'b0;
      wait_sector(8'h06);
      repeat (8) @(negedge sys_clk_i);
      cmp("split_len", 16'd286, 16'(wq.size()));
      foreach (wq[i]) begin
         cmp("split_byte", {8'h00, eq[i + 34]}, {8'h00, wq[i]});
      end
      print_verdict();
   end
endmodule
